// ### src/ecp_pkg.sv
// Purpose: Shared constants and carriers for the port mode control block.
// Assumes: Byte-wide register port at the documented offsets.
// Notes:   Offsets are relative to the port base address.
package ecp_pkg;
	localparam logic [10:0] OFS_QUEUE = 11'h400;
	localparam logic [10:0] OFS_CFGB  = 11'h401;
	localparam logic [10:0] OFS_XCTL  = 11'h402;
	localparam logic [7:0]  CAP_VALUE = 8'h10;
	localparam int MODE_HI   = 7;
	localparam int MODE_LO   = 5;
	localparam int FLT_BIT   = 4;
	localparam int DMA_BIT   = 3;
	localparam int SVC_BIT   = 2;
	localparam int FULL_BIT  = 1;
	localparam int EMPTY_BIT = 0;
	localparam logic [7:0] XCTL_RST = 8'h15;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_AW    = 3;
	localparam int PULSE_CYC  = 4;

	typedef enum logic [2:0] {
		MODE_STD  = 3'h0,
		MODE_BIDI = 3'h1,
		MODE_FIFO = 3'h2,
		MODE_ECP  = 3'h3,
		MODE_EPP  = 3'h4,
		MODE_RSVD = 3'h5,
		MODE_TEST = 3'h6,
		MODE_CFG  = 3'h7
	} mode_t;

	typedef enum logic [1:0] {
		HS_IDLE  = 2'b00,
		HS_SETUP = 2'b01,
		HS_PULSE = 2'b11,
		HS_HOLD  = 2'b10
	} hs_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [10:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic strobe_low;
		logic auto_feed_low;
		logic initialize_low;
		logic select_request_low;
	} ctl_pins_t;
endpackage

// ### src/byte_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides.
// Assumes: One clock; flush empties it in one cycle.
// Notes:   Count output lets the owner compute free and valid bytes.
`timescale 1ns/100ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8,
	parameter int AW    = 3
) (
	input  wire logic             clk_sys_i,    // System clock.
	input  wire logic             arst_n_i,     // Async reset, low.
	input  wire logic             flush_i,      // Empty the FIFO.
	input  wire logic             in_valid_i,   // Write request.
	output logic                  in_ready_o,   // Space available.
	input  wire logic [WIDTH-1:0] in_data_i,    // Write data.
	output logic                  out_valid_o,  // Data available.
	input  wire logic             out_ready_i,  // Read accept.
	output logic [WIDTH-1:0]      out_data_o,   // Head data.
	output logic [AW:0]           count_o       // Bytes held.
);
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
	} fifo_st_t;

	fifo_st_t st_q, st_d;
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic push, pop;

	// Handshakes are combinational from the count.
	assign in_ready_o  = (st_q.cnt != (AW+1)'(DEPTH));
	assign out_valid_o = (st_q.cnt != '0);
	assign out_data_o  = mem_q[st_q.rp];
	assign count_o     = st_q.cnt;
	assign push        = in_valid_i & in_ready_o & ~flush_i;
	assign pop         = out_valid_o & out_ready_i & ~flush_i;

	// Pointer and count update.
	always_comb begin
		st_d = st_q;
		if (flush_i) begin
			st_d = '0;
		end else begin
			if (push) st_d.wp = st_q.wp + 1'b1;
			if (pop) st_d.rp = st_q.rp + 1'b1;
			st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) st_q <= '0;
		else st_q <= st_d;
	end

	// Storage needs no reset; empty state hides stale words.
	always_ff @(posedge clk_sys_i) begin
		if (push) mem_q[st_q.wp] <= in_data_i;
	end
endmodule

// ### src/ecp_port_mode_control.sv
// What this block does
// - Three-bit mode field selects port operation.
// - Fault falling edge interrupts in ECP mode.
// - Enabling fault interrupt while asserted interrupts.
// - DMA gate permits DMA only when unmasked.
// - Mask set blocks DMA and service interrupts.
// - Hardware sets mask after every service interrupt.
// - Forward PIO: free bytes reach threshold sets mask.
// - Reverse PIO: valid bytes reach threshold sets mask.
// - Read-only full and empty FIFO flags.
// - Standard mode resets FIFO, open-collector controls.
// - Bidirectional: direction tri-states data, pins read.
// - FIFO mode sends bytes by compatibility handshake.
// - ECP forward sends queue; reverse fills queue.
// - Mode 100 EPP only if option set.
// - Test mode: FIFO works, nothing transmitted.
// - Configuration mode maps config registers A, B.
// - Config B 5:3 encodes interrupt line.
// - Config B 2:0 encodes DMA channel.
// - Leave extended modes only via standard/bidirectional.
// - ECP or FIFO mode starts automatic handshake.
// - Returning to standard drops controls, discards data.
// - Reverse abort deasserts auto-feed immediately.
// - Service interrupt is short low pulse, then released.
// - Threshold 1..16 programmed as 0..15.
//
// Purpose: Extended control register and mode logic of a parallel port.
// Assumes: Host strobes are one-cycle pulses synchronous to clk_sys_i.
// Notes:   Handshake engines are simplified; peripheral status inputs
//          are taken as synchronous.
`timescale 1ns/100ps
module ecp_port_mode_control #(
	parameter int THR_W = 4
) (
	input  wire logic              clk_sys_i,        // 40 MHz clock.
	input  wire logic              arst_n_i,         // Async reset, low.
	input  wire ecp_pkg::reg_req_t req_i,            // Register access.
	output logic [7:0]             rdata_o,          // Read data.
	input  wire logic              direction_i,      // Control dir bit.
	input  wire logic              epp_option_setting_i, // EPP enabled.
	input  wire logic [THR_W-1:0]  write_service_level_i, // Thr minus 1.
	input  wire logic [THR_W-1:0]  read_service_level_i,  // Thr minus 1.
	input  wire logic [3:0]        irq_select_i,     // Chosen IRQ line.
	input  wire logic [1:0]        dma_select_i,     // Chosen DMA channel.
	input  wire logic              irq_line_level_i, // IRQ line level.
	input  wire logic              dma_ack_i,        // DMA cycle strobe.
	input  wire logic              dma_tc_i,         // Terminal count.
	output logic                   dma_req_o,        // DMA request.
	input  wire logic              fault_input_low_i,// Fault pin.
	input  wire logic              busy_i,           // Busy pin.
	input  wire logic              periph_ack_low_i, // Ack pin (ECP).
	input  wire logic [7:0]        pd_i,             // Data pin levels.
	output logic [7:0]             pd_o,             // Data pin drive.
	output logic                   pd_oe_o,          // Data drive enable.
	output ecp_pkg::ctl_pins_t     ctl_o,            // Control levels.
	output logic [3:0]             ctl_oe_o,         // Control enables.
	output logic                   mode_epp_o,       // EPP active.
	output logic                   irq_o,            // IRQ drive value.
	output logic                   irq_oe_o          // IRQ drive enable.
);
	typedef struct packed {
		logic [7:0]   xctl;
		logic         fault_prev;
		logic [2:0]   pulse;
		ecp_pkg::hs_t hs;
		logic [7:0]   pd;
		logic         strobe_low;
		logic         auto_feed_low;
		logic         tag_cmd;
		logic         svc_arm;
	} state_t;

	state_t st_q, st_d;
	ecp_pkg::mode_t mode;
	logic [8:0] fifo_in, fifo_out;
	logic [ecp_pkg::FIFO_AW:0] fcount;
	logic f_in_rdy, f_out_vld, f_flush, f_push, f_pop;
	logic [8:0] push_data;
	logic hit_q, hit_c, hit_x, cfg_map;
	logic [4:0] free_b, thr_w, thr_r;
	logic [2:0] irq_code, dma_code;
	logic fault_evt, svc_evt, svc_cond, xmit_fwd, recv_rev;

	assign mode = ecp_pkg::mode_t'(st_q.xctl[ecp_pkg::MODE_HI:
		ecp_pkg::MODE_LO]);
	assign hit_q = (req_i.addr == ecp_pkg::OFS_QUEUE);
	assign hit_c = (req_i.addr == ecp_pkg::OFS_CFGB);
	assign hit_x = (req_i.addr == ecp_pkg::OFS_XCTL);
	assign cfg_map = (mode == ecp_pkg::MODE_CFG);

	// FIFO traffic: host, DMA or the reverse engine pushes; engine, host or DMA pops.
	assign xmit_fwd = ~direction_i & ((mode == ecp_pkg::MODE_FIFO) |
		(mode == ecp_pkg::MODE_ECP));
	assign recv_rev = direction_i & (mode == ecp_pkg::MODE_ECP);
	assign f_flush  = (mode == ecp_pkg::MODE_STD) |
		(mode == ecp_pkg::MODE_BIDI);
	assign push_data = recv_rev ? {1'b0, pd_i} : {1'b0, req_i.wdata};
	always_comb begin
		f_push = 1'b0;
		if (recv_rev) begin
			f_push = (st_q.hs == ecp_pkg::HS_PULSE) & ~periph_ack_low_i;
		end else if (!cfg_map) begin
			f_push = (hit_q & req_i.wr) | (dma_ack_i & ~direction_i);
		end
	end
	assign fifo_in = push_data;
	// Reads come from the head in test and reverse modes; a read of an
	// empty FIFO simply returns the head again without popping.
	assign f_pop = (!cfg_map & !xmit_fwd & ((hit_q & req_i.rd) |
		(dma_ack_i & direction_i))) |
		(xmit_fwd & (st_q.hs == ecp_pkg::HS_HOLD) & ~busy_i);

	byte_fifo #(
		.WIDTH (9),
		.DEPTH (ecp_pkg::FIFO_DEPTH),
		.AW    (ecp_pkg::FIFO_AW)
	) u_fifo (
		.clk_sys_i   (clk_sys_i),
		.arst_n_i    (arst_n_i),
		.flush_i     (f_flush),
		.in_valid_i  (f_push),
		.in_ready_o  (f_in_rdy),
		.in_data_i   (fifo_in),
		.out_valid_o (f_out_vld),
		.out_ready_i (f_pop),
		.out_data_o  (fifo_out),
		.count_o     (fcount)
	);

	// Thresholds are stored one less than the byte count.
	assign thr_w  = 5'(write_service_level_i) + 5'h01;
	assign thr_r  = 5'(read_service_level_i) + 5'h01;
	assign free_b = 5'(ecp_pkg::FIFO_DEPTH) - 5'(fcount);

	// Service condition per DMA gate and direction.
	always_comb begin
		if (st_q.xctl[ecp_pkg::DMA_BIT]) begin
			svc_cond = dma_tc_i;
		end else if (!direction_i) begin
			svc_cond = (free_b >= thr_w);
		end else begin
			svc_cond = (5'(fcount) >= thr_r);
		end
	end
	// A level condition fires immediately when the mask is cleared.
	assign svc_evt = ~st_q.xctl[ecp_pkg::SVC_BIT] & svc_cond &
		~f_flush;
	assign fault_evt = (mode == ecp_pkg::MODE_ECP) &
		~st_q.xctl[ecp_pkg::FLT_BIT] &
		((st_q.fault_prev & ~fault_input_low_i) | st_q.svc_arm);

	// DMA only while gated on and unmasked.
	assign dma_req_o = st_q.xctl[ecp_pkg::DMA_BIT] &
		~st_q.xctl[ecp_pkg::SVC_BIT] & ~cfg_map &
		(direction_i ? f_out_vld : f_in_rdy);

	// Resource encodings for configuration register B.
	always_comb begin
		case (irq_select_i)
			4'hF:    irq_code = 3'h6;
			4'hE:    irq_code = 3'h5;
			4'hB:    irq_code = 3'h4;
			4'hA:    irq_code = 3'h3;
			4'h9:    irq_code = 3'h2;
			4'h7:    irq_code = 3'h1;
			4'h5:    irq_code = 3'h7;
			default: irq_code = 3'h0;
		endcase
		case (dma_select_i)
			2'h3:    dma_code = 3'h3;
			2'h2:    dma_code = 3'h2;
			2'h1:    dma_code = 3'h1;
			default: dma_code = 3'h0;
		endcase
	end

	// Next-state logic for the control register and handshakes.
	always_comb begin
		logic [2:0] new_mode;
		logic       mode_ok;
		st_d = st_q;
		new_mode = req_i.wdata[ecp_pkg::MODE_HI:ecp_pkg::MODE_LO];
		mode_ok = (mode == ecp_pkg::MODE_STD) |
			(mode == ecp_pkg::MODE_BIDI) |
			(new_mode == ecp_pkg::MODE_STD) |
			(new_mode == ecp_pkg::MODE_BIDI);
		st_d.fault_prev = fault_input_low_i;
		st_d.svc_arm = 1'b0;
		if (req_i.wr & hit_x) begin
			if (mode_ok) begin
				st_d.xctl[ecp_pkg::MODE_HI:ecp_pkg::MODE_LO] = new_mode;
			end
			st_d.xctl[ecp_pkg::FLT_BIT] = req_i.wdata[ecp_pkg::FLT_BIT];
			st_d.xctl[ecp_pkg::DMA_BIT] = req_i.wdata[ecp_pkg::DMA_BIT];
			st_d.xctl[ecp_pkg::SVC_BIT] = req_i.wdata[ecp_pkg::SVC_BIT];
			st_d.svc_arm = st_q.xctl[ecp_pkg::FLT_BIT] &
				~req_i.wdata[ecp_pkg::FLT_BIT] & ~fault_input_low_i;
		end
		// Hardware set wins over a software clear in the same cycle.
		if (svc_evt) st_d.xctl[ecp_pkg::SVC_BIT] = 1'b1;
		// Short low pulse on the shared line, then release.
		if (svc_evt | fault_evt) begin
			st_d.pulse = 3'(ecp_pkg::PULSE_CYC);
		end else if (st_q.pulse != 3'h0) begin
			st_d.pulse = st_q.pulse - 3'h1;
		end
		// Transmit handshake: setup, strobe pulse, wait busy low.
		case (st_q.hs)
			ecp_pkg::HS_IDLE: begin
				if (xmit_fwd & f_out_vld & ~busy_i) begin
					st_d.pd = fifo_out[7:0];
					st_d.tag_cmd = fifo_out[8];
					st_d.hs = ecp_pkg::HS_SETUP;
				end else if (recv_rev) begin
					st_d.auto_feed_low = 1'b0;
					if (!periph_ack_low_i && f_in_rdy) begin
						st_d.hs = ecp_pkg::HS_PULSE;
					end
				end
			end
			ecp_pkg::HS_SETUP: begin
				st_d.strobe_low = 1'b0;
				st_d.hs = ecp_pkg::HS_PULSE;
			end
			ecp_pkg::HS_PULSE: begin
				st_d.strobe_low = 1'b1;
				st_d.auto_feed_low = 1'b1;
				st_d.hs = ecp_pkg::HS_HOLD;
			end
			ecp_pkg::HS_HOLD: begin
				if (!busy_i || recv_rev) st_d.hs = ecp_pkg::HS_IDLE;
			end
			default: st_d.hs = ecp_pkg::HS_IDLE;
		endcase
		// Leaving an automatic mode drops controls at once.
		if (f_flush) begin
			st_d.hs = ecp_pkg::HS_IDLE;
			st_d.strobe_low = 1'b1;
			st_d.auto_feed_low = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_q <= '{xctl: ecp_pkg::XCTL_RST, fault_prev: 1'b1,
				pulse: 3'h0, hs: ecp_pkg::HS_IDLE, pd: 8'h00,
				strobe_low: 1'b1, auto_feed_low: 1'b1, tag_cmd: 1'b0,
				svc_arm: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	// Read mux; status bits reflect live FIFO state.
	always_comb begin
		rdata_o = 8'h00;
		if (hit_x) begin
			rdata_o = {st_q.xctl[7:2], ~f_in_rdy, ~f_out_vld};
		end else if (hit_q & cfg_map) begin
			rdata_o = ecp_pkg::CAP_VALUE;
		end else if (hit_c & cfg_map) begin
			rdata_o = {1'b0, irq_line_level_i, irq_code, dma_code};
		end else if (hit_q) begin
			rdata_o = fifo_out[7:0];
		end
	end

	// Pin drive: open collector only in standard mode.
	assign ctl_o.strobe_low         = st_q.strobe_low;
	assign ctl_o.auto_feed_low      = st_q.auto_feed_low;
	assign ctl_o.initialize_low     = 1'b1;
	assign ctl_o.select_request_low = 1'b1;
	assign ctl_oe_o = (mode == ecp_pkg::MODE_STD) ?
		{~ctl_o.strobe_low, ~ctl_o.auto_feed_low, 2'b00} : 4'hF;
	assign pd_o    = st_q.pd;
	assign pd_oe_o = ~(direction_i & (mode != ecp_pkg::MODE_STD) &
		(mode != ecp_pkg::MODE_FIFO)) | (mode == ecp_pkg::MODE_TEST)
		& ~direction_i;
	assign mode_epp_o = (mode == ecp_pkg::MODE_EPP) &
		epp_option_setting_i;
	assign irq_o    = 1'b0;
	assign irq_oe_o = (st_q.pulse != 3'h0);
endmodule

// ### dv/periph_model.sv
// Purpose: Printer side of the port, taking bytes on the strobe.
// Assumes: Strobe and data are the block's registered outputs.
// Notes:   Released data lines show the inverse of the last driven byte.
`timescale 1ns/100ps
module periph_model #(
	parameter int BUSY_CYC = 3
) (
	input  wire logic       clk_sys_i,    // System clock.
	input  wire logic       strobe_low_i, // Strobe from the port.
	input  wire logic [7:0] pd_o_i,       // Data driven by the port.
	input  wire logic       pd_oe_i,      // Port drives the data.
	output logic            busy_o,       // Busy to the port.
	output logic [7:0]      pd_i_o,       // Data pin levels.
	output int              rx_cnt_o,     // Bytes taken.
	output logic [7:0]      rx_last_o     // Last byte taken.
);
	logic       strobe_q = 1'b1;
	logic [7:0] last_q = 8'h00;
	int         busy_cnt = 0;
	initial rx_cnt_o = 0;
	// Floating lines must not echo the old byte, so they show its inverse.
	assign pd_i_o = pd_oe_i ? pd_o_i : ~last_q;
	assign busy_o = (busy_cnt > 0);
	// A falling strobe latches a byte and raises busy for a while.
	always @(posedge clk_sys_i) begin
		strobe_q <= strobe_low_i;
		if (pd_oe_i) last_q <= pd_o_i;
		if (strobe_q && !strobe_low_i) begin
			rx_last_o <= pd_o_i;
			rx_cnt_o  <= rx_cnt_o + 1;
			busy_cnt  <= BUSY_CYC;
		end else if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
	end
endmodule

// ### dv/ecp_port_mode_control_checker.sv
// Purpose: Port-level checks for the mode control block.
// Assumes: Mode writes follow the switching rule kept in the shadow.
// Notes:   The shadow mirrors only bits that software writes.
`timescale 1ns/100ps
module ecp_port_mode_control_checker (
	input  wire logic               clk_sys_i,            // Clock.
	input  wire logic               arst_n_i,             // Reset, low.
	input  wire ecp_pkg::reg_req_t  req_i,                // Access.
	input  wire logic [7:0]         rdata_o,              // Read data.
	input  wire logic               direction_i,          // Direction.
	input  wire logic               epp_option_setting_i, // EPP option.
	input  wire logic [3:0]         irq_select_i,         // IRQ line.
	input  wire logic [1:0]         dma_select_i,         // DMA channel.
	input  wire logic               fault_input_low_i,    // Fault pin.
	input  wire logic               dma_req_o,            // DMA request.
	input  wire logic               pd_oe_o,              // Data enable.
	input  wire ecp_pkg::ctl_pins_t ctl_o,                // Controls.
	input  wire logic [3:0]         ctl_oe_o,             // Enables.
	input  wire logic               mode_epp_o,           // EPP active.
	input  wire logic               irq_o,                // IRQ value.
	input  wire logic               irq_oe_o              // IRQ enable.
);
	logic [2:0] mode_q;
	logic       flt_q;
	logic       dma_q;
	logic [2:0] irq_enc;
	logic       xwr;
	assign xwr = req_i.wr && req_i.addr == ecp_pkg::OFS_XCTL;
	// Shadow of the control bits; a refused mode move keeps the old mode.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mode_q <= 3'h0;
			flt_q  <= 1'b1;
			dma_q  <= 1'b0;
		end else if (xwr) begin
			flt_q <= req_i.wdata[4];
			dma_q <= req_i.wdata[3];
			if (mode_q < 3'h2 || req_i.wdata[7:5] < 3'h2) begin
				mode_q <= req_i.wdata[7:5];
			end
		end
	end
	// Expected code of the selected interrupt line.
	always_comb begin
		case (irq_select_i)
			4'hF:    irq_enc = 3'h6;
			4'hE:    irq_enc = 3'h5;
			4'hB:    irq_enc = 3'h4;
			4'hA:    irq_enc = 3'h3;
			4'h9:    irq_enc = 3'h2;
			4'h7:    irq_enc = 3'h1;
			4'h5:    irq_enc = 3'h7;
			default: irq_enc = 3'h0;
		endcase
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);
	a_mode_readback: assert property (
		req_i.addr == ecp_pkg::OFS_XCTL |-> rdata_o[7:5] == mode_q)
		else $error("mode field differs from expected");
	a_dma_gate_off: assert property (
		dma_req_o |-> dma_q) else $error("DMA request while gate is off");
	a_mask_blocks_dma: assert property (
		req_i.addr == ecp_pkg::OFS_XCTL && rdata_o[2] |-> !dma_req_o)
		else $error("DMA request while service mask is set");
	a_flags_exclusive: assert property (
		req_i.addr == ecp_pkg::OFS_XCTL |-> !(rdata_o[1] && rdata_o[0]))
		else $error("full and empty both set");
	a_open_collector: assert property (
		mode_q == 3'h0 |-> ctl_oe_o == ~4'(ctl_o) && pd_oe_o)
		else $error("standard mode drive wrong");
	a_push_pull: assert property (
		mode_q != 3'h0 |-> ctl_oe_o == 4'hF)
		else $error("controls not push-pull");
	a_bidi_direction: assert property (
		mode_q == 3'h1 |-> pd_oe_o == !direction_i)
		else $error("data enable ignores direction");
	a_epp_select: assert property (
		mode_epp_o == (mode_q == 3'h4 && epp_option_setting_i))
		else $error("EPP flag wrong");
	a_resource_codes: assert property (
		mode_q == 3'h7 && req_i.addr == ecp_pkg::OFS_CFGB
		|-> rdata_o[5:0] == {irq_enc, 1'b0, dma_select_i})
		else $error("resource codes wrong");
	a_irq_pulse_low: assert property (
		$rose(irq_oe_o) |-> (irq_oe_o && !irq_o)[*4])
		else $error("interrupt pulse too short or not low");
	a_fault_edge_irq: assert property (
		$fell(fault_input_low_i) && mode_q == 3'h3 && !flt_q
		|-> ##[1:3] irq_oe_o) else $error("fault edge gave no interrupt");
endmodule
bind ecp_port_mode_control ecp_port_mode_control_checker checker_i (.*);

// ### dv/tb_ecp_port_mode_control.sv
// Purpose: Self-checking bench for the port mode control block.
// Assumes: Registers are reached at offsets 0x400 to 0x402 only.
// Notes:   Random data and levels come from a fixed seed.
`timescale 1ns/100ps
module tb_ecp_port_mode_control;
	logic               clk_sys_i = 1'b0;
	logic               arst_n_i = 1'b0;
	ecp_pkg::reg_req_t  req_i = '0;
	logic               dir = 1'b0;
	logic               epp = 1'b0;
	logic [3:0]         wlvl = 4'h0;
	logic [3:0]         rlvl = 4'h0;
	logic [3:0]         irq_sel = 4'h0;
	logic [1:0]         dma_sel = 2'h0;
	logic               irq_lvl = 1'b0;
	logic               dma_ack = 1'b0;
	logic               dma_tc = 1'b0;
	logic               fault_low = 1'b1;
	logic               ack_low = 1'b1;
	logic [7:0]         rdata, pd_in, pd_out, rx_last, val;
	logic               dma_req, busy, pd_oe, irq, irq_oe, epp_on, seen;
	ecp_pkg::ctl_pins_t ctl;
	logic [3:0]         ctl_oe;
	logic [2:0]         mode, mode_n;
	logic [7:0]         q[$];
	int                 failures = 0, checks = 0, seed = 23, rx_cnt, n;
	always #12.5 clk_sys_i = ~clk_sys_i;
	ecp_port_mode_control ecp_port_mode_control_i (.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i), .req_i(req_i), .rdata_o(rdata),
		.direction_i(dir), .epp_option_setting_i(epp),
		.write_service_level_i(wlvl), .read_service_level_i(rlvl),
		.irq_select_i(irq_sel), .dma_select_i(dma_sel),
		.irq_line_level_i(irq_lvl), .dma_ack_i(dma_ack), .dma_tc_i(dma_tc),
		.dma_req_o(dma_req), .fault_input_low_i(fault_low), .busy_i(busy),
		.periph_ack_low_i(ack_low), .pd_i(pd_in), .pd_o(pd_out),
		.pd_oe_o(pd_oe), .ctl_o(ctl), .ctl_oe_o(ctl_oe),
		.mode_epp_o(epp_on), .irq_o(irq), .irq_oe_o(irq_oe));
	periph_model periph_model_i (.clk_sys_i(clk_sys_i),
		.strobe_low_i(ctl.strobe_low), .pd_o_i(pd_out), .pd_oe_i(pd_oe),
		.busy_o(busy), .pd_i_o(pd_in), .rx_cnt_o(rx_cnt),
		.rx_last_o(rx_last));
	task automatic check(input logic [7:0] s, input logic [7:0] e);
		checks++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic complete_run();
		if (failures == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Bus cycles: request held one cycle, then parked on the control reg.
	task automatic wr(input logic [10:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		req_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_sys_i);
		req_i <= '{wr: 1'b0, rd: 1'b0, addr: ecp_pkg::OFS_XCTL, wdata: d};
	endtask
	task automatic rd(input logic [10:0] a, output logic [7:0] d);
		@(posedge clk_sys_i);
		req_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		#1 d = rdata;
		@(posedge clk_sys_i);
		req_i <= '{wr: 1'b0, rd: 1'b0, addr: ecp_pkg::OFS_XCTL, wdata: d};
	endtask
	task automatic xw(input logic [2:0] m, input logic [4:0] b);
		wr(ecp_pkg::OFS_XCTL, {m, b});
	endtask
	// Window long enough to swallow one whole interrupt pulse.
	task automatic wait_irq(input logic e);
		seen = 1'b0;
		repeat (10) begin
			@(posedge clk_sys_i);
			#1 if (irq_oe === 1'b1) seen = 1'b1;
		end
		check({7'h00, seen}, {7'h00, e});
	endtask
	// Expected resource byte: line level, interrupt code, DMA code.
	function automatic logic [7:0] exp_cfgb(input logic [3:0] i,
		input logic [1:0] d, input logic l);
		logic [2:0] c;
		case (i)
			4'hF:    c = 3'h6;
			4'hE:    c = 3'h5;
			4'hB:    c = 3'h4;
			4'hA:    c = 3'h3;
			4'h9:    c = 3'h2;
			4'h7:    c = 3'h1;
			4'h5:    c = 3'h7;
			default: c = 3'h0;
		endcase
		return {1'b0, l, c, 1'b0, d};
	endfunction
	function automatic logic [2:0] next_mode(input logic [2:0] c, n);
		return (c < 3'h2 || n < 3'h2) ? n : c;
	endfunction
	initial begin
		#750000;
		failures++;
		complete_run();
	end
	initial begin
		repeat (4) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		rd(ecp_pkg::OFS_XCTL, val);
		check(val, ecp_pkg::XCTL_RST);
		// Random mode walk; refused moves must keep the old mode.
		mode = 3'h0;
		for (int i = 0; i < 40; i++) begin
			mode_n = 3'($random(seed));
			epp <= 1'($random(seed));
			irq_sel <= 4'($random(seed));
			dma_sel <= 2'($random(seed));
			irq_lvl <= 1'($random(seed));
			xw(mode_n, 5'h14);
			mode = next_mode(mode, mode_n);
			rd(ecp_pkg::OFS_XCTL, val);
			check({5'h00, val[7:5]}, {5'h00, mode});
			if (mode == 3'h7) begin
				rd(ecp_pkg::OFS_QUEUE, val);
				check(val, ecp_pkg::CAP_VALUE);
				rd(ecp_pkg::OFS_CFGB, val);
				check(val, exp_cfgb(irq_sel, dma_sel, irq_lvl));
			end
		end
		// Test mode, forward: free bytes against the write level.
		xw(3'h0, 5'h14);
		wlvl <= 4'($random(seed) & 7);
		rlvl <= 4'($random(seed) & 7);
		xw(3'h6, 5'h14);
		xw(3'h6, 5'h10);
		wait_irq(1'b1);
		rd(ecp_pkg::OFS_XCTL, val);
		check({7'h00, val[2]}, 8'h01);
		n = rx_cnt;
		for (int i = 0; i < 9; i++) begin
			q.push_back(8'($random(seed)));
			wr(ecp_pkg::OFS_QUEUE, q[i]);
		end
		void'(q.pop_back());
		rd(ecp_pkg::OFS_XCTL, val);
		check({6'h00, val[1:0]}, 8'h02);
		check(8'(rx_cnt - n), 8'h00);
		xw(3'h6, 5'h10);
		wait_irq(1'b0);
		// Reverse with a full queue: the mask is already clear.
		dir <= 1'b1;
		wait_irq(1'b1);
		for (int i = 0; i < 8; i++) begin
			rd(ecp_pkg::OFS_QUEUE, val);
			check(val, q.pop_front());
		end
		rd(ecp_pkg::OFS_XCTL, val);
		check({6'h00, val[1:0]}, 8'h01);
		xw(3'h6, 5'h10);
		wait_irq(1'b0);
		// Leftover bytes are dropped on return to standard mode.
		wr(ecp_pkg::OFS_QUEUE, 8'h5A);
		xw(3'h0, 5'h14);
		dir <= 1'b0;
		rd(ecp_pkg::OFS_XCTL, val);
		check({7'h00, val[0]}, 8'h01);
		// FIFO mode sends written bytes to the printer by itself.
		xw(3'h2, 5'h14);
		n = rx_cnt + 3;
		for (int i = 0; i < 3; i++) begin
			val = 8'($random(seed));
			wr(ecp_pkg::OFS_QUEUE, val);
		end
		for (int i = 0; i < 400 && rx_cnt != n; i++) @(posedge clk_sys_i);
		check(8'(rx_cnt), 8'(n));
		check(rx_last, val);
		// DMA run ended by terminal count, which sets the mask.
		xw(3'h2, 5'h18);
		#1 check({7'h00, dma_req}, 8'h01);
		@(posedge clk_sys_i);
		dma_ack <= 1'b1;
		@(posedge clk_sys_i);
		dma_ack <= 1'b0;
		dma_tc <= 1'b1;
		@(posedge clk_sys_i);
		dma_tc <= 1'b0;
		wait_irq(1'b1);
		check({7'h00, dma_req}, 8'h00);
		// Fault interrupts in ECP mode.
		xw(3'h0, 5'h14);
		xw(3'h3, 5'h14);
		fault_low <= 1'b0;
		wait_irq(1'b0);
		xw(3'h3, 5'h04);
		wait_irq(1'b1);
		fault_low <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		fault_low <= 1'b0;
		wait_irq(1'b1);
		// Reverse ECP: auto-feed asks, bytes fill the queue, abort drops it.
		xw(3'h1, 5'h14);
		dir <= 1'b1;
		xw(3'h3, 5'h14);
		repeat (2) @(posedge clk_sys_i);
		#1 check({7'h00, ctl.auto_feed_low}, 8'h00);
		@(posedge clk_sys_i);
		ack_low <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		ack_low <= 1'b1;
		rd(ecp_pkg::OFS_XCTL, val);
		check({7'h00, val[0]}, 8'h00);
		xw(3'h1, 5'h14);
		@(posedge clk_sys_i);
		#1 check({7'h00, ctl.auto_feed_low}, 8'h01);
		dir <= 1'b0;
		xw(3'h0, 5'h14);
		complete_run();
	end
endmodule
